// File: rtl/dchab_pkg.sv
/*
  package of the control-port d channel byte access block: register addresses,
  field positions, reset values, status codes, timing and carrier types.
  assumes a single 25 MHz clock and a synchronous active-high reset.
*/
package dchab_pkg;

  // ***********************************************************
  // register map (byte address, registers four bytes apart)
  // ***********************************************************
  localparam logic [7:0] DCHAB_ADDR_RESET_CTRL   = 8'h00; // reset_ctrl_nibble
  localparam logic [7:0] DCHAB_ADDR_STATUS_CODE  = 8'h04; // irq_status_code_nibble
  localparam logic [7:0] DCHAB_ADDR_ACT_CTRL     = 8'h08; // activation_ctrl_nibble
  localparam logic [7:0] DCHAB_ADDR_IRQ_SOURCE   = 8'h0C; // irq_source_nibble
  localparam logic [7:0] DCHAB_ADDR_IRQ_ENABLE   = 8'h10; // interrupt enable nibble
  localparam logic [7:0] DCHAB_ADDR_BYTE_CTRL    = 8'h14; // byte_ctrl_overlay_select
  localparam logic [7:0] DCHAB_ADDR_DCHAN_DATA   = 8'h18; // dchan_data_overlay
  localparam logic [7:0] DCHAB_ADDR_EVT_STATUS   = 8'h1C; // sticky event status
  localparam logic [7:0] DCHAB_ADDR_EVT_MASK     = 8'h20; // event mask

  // ***********************************************************
  // field positions
  // ***********************************************************
  localparam int DCHAB_BIT_SOFT_RESET    = 3;
  localparam int DCHAB_BIT_ACT_REQUEST   = 3;
  localparam int DCHAB_BIT_CUST_ENABLE   = 0;
  localparam int DCHAB_BIT_SRC_ACT_GROUP = 3;
  localparam int DCHAB_BIT_HOST_DCHAN_EN = 1;
  localparam int DCHAB_BIT_OVERLAY_SEL   = 0;
  localparam int DCHAB_EVT_BYTE          = 0;
  localparam int DCHAB_EVT_ACT_OK        = 1;
  localparam int DCHAB_EVT_ACT_ERR       = 2;

  // ***********************************************************
  // codes and reset values
  // ***********************************************************
  localparam logic [3:0] DCHAB_IRQ_EN_ACT_DCHAN = 4'h8;
  localparam logic [3:0] DCHAB_CODE_DCHAN_BYTE  = 4'hF;
  localparam logic [3:0] DCHAB_CODE_ACT_OK_A    = 4'hA;
  localparam logic [3:0] DCHAB_CODE_ACT_OK_B    = 4'hB;
  localparam logic [3:0] DCHAB_CODE_ACT_ERROR   = 4'h4;
  localparam logic [3:0] DCHAB_CODE_NONE        = 4'h0;
  localparam logic [3:0] DCHAB_RST_NIBBLE       = 4'h0;
  localparam logic [7:0] DCHAB_RST_BYTE         = 8'h00;
  localparam logic [2:0] DCHAB_RST_EVT          = 3'h0;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int CLK_HZ             = 25_000_000;
  localparam int DCHAN_PERIOD_US    = 500;
  localparam int DCHAN_PERIOD_CYC   = (CLK_HZ / 1_000_000) * DCHAN_PERIOD_US;

  // ***********************************************************
  // carriers
  // ***********************************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dchab_req_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] code;
  } dchab_act_evt_t;

endpackage : dchab_pkg

// File: rtl/dchab_top.sv
/*
  d channel byte access over the host control port: overlay data register,
  status code nibble, 500 us byte period, deferred activation interrupt.
  assumes the line side reports activation outcomes as one-cycle strobes and holds
  each received byte on LINE_RX_BYTE, synchronous to CLK; host port has no wait states.
*/
// Overview of operation
// - data register live once activated, transparent, enabled
// - load code F on each received byte while the interrupt enable nibble is 8
// - byte interrupt every 500 microseconds
// - coincident activation interrupt deferred until data read
// - activation request bit starts line activation
// - source bit 3 flags pending activation group
// - code A or B means success; host enables data
// - code 4 means activation error
module dchab_top
  import dchab_pkg::*;
(
  input  wire logic                 CLK,
  input  wire logic                 SYS_RST,
  input  wire dchab_pkg::dchab_req_t HOST_REQ,
  output logic      [7:0]           HOST_RDATA,
  output logic                      IRQ,
  input  wire dchab_pkg::dchab_act_evt_t LINE_ACT_EVT,
  input  wire logic                 LINE_TRANSPARENT,
  input  wire logic      [7:0]      LINE_RX_BYTE,
  output logic      [7:0]           LINE_TX_BYTE,
  output logic                      LINE_TX_STROBE,
  output logic                      LINE_ACT_REQ,
  output logic                      LINE_CUST_EN,
  output logic                      LINE_SOFT_RESET
);
  import dchab_pkg::*;

  // ***********************************************************
  // registers
  // ***********************************************************
  logic [3:0]  reset_ctrl;
  logic [3:0]  status_code;
  logic [3:0]  act_ctrl;
  logic [3:0]  irq_enable;
  logic [1:0]  byte_ctrl;
  logic [7:0]  rx_byte;
  logic [7:0]  tx_byte;
  logic        activated;
  logic        act_pending;
  logic [3:0]  act_pending_code;
  logic [2:0]  evt_status;
  logic [2:0]  evt_mask;
  logic [14:0] period_cnt;

  // ***********************************************************
  // decode
  // ***********************************************************
  wire wr_reset  = HOST_REQ.wr && HOST_REQ.addr == DCHAB_ADDR_RESET_CTRL;
  wire wr_act    = HOST_REQ.wr && HOST_REQ.addr == DCHAB_ADDR_ACT_CTRL;
  wire wr_irqen  = HOST_REQ.wr && HOST_REQ.addr == DCHAB_ADDR_IRQ_ENABLE;
  wire wr_bctrl  = HOST_REQ.wr && HOST_REQ.addr == DCHAB_ADDR_BYTE_CTRL;
  wire wr_data   = HOST_REQ.wr && HOST_REQ.addr == DCHAB_ADDR_DCHAN_DATA;
  wire wr_evt    = HOST_REQ.wr && HOST_REQ.addr == DCHAB_ADDR_EVT_STATUS;
  wire wr_mask   = HOST_REQ.wr && HOST_REQ.addr == DCHAB_ADDR_EVT_MASK;
  wire rd_data   = HOST_REQ.rd && HOST_REQ.addr == DCHAB_ADDR_DCHAN_DATA;

  // both success codes are decoded for the live outcome and for a released one
  function automatic logic is_act_ok(input logic [3:0] c);
    return c == DCHAB_CODE_ACT_OK_A || c == DCHAB_CODE_ACT_OK_B;
  endfunction : is_act_ok

  wire host_en    = byte_ctrl[DCHAB_BIT_HOST_DCHAN_EN];
  wire irq_en     = irq_enable == DCHAB_IRQ_EN_ACT_DCHAN;
  // path is live only after activation with transparent data
  wire path_live  = activated && LINE_TRANSPARENT && host_en;
  wire period_end = period_cnt == 15'(DCHAN_PERIOD_CYC - 1);
  wire byte_tick  = path_live && period_end;
  wire byte_irq   = byte_tick && irq_en;
  wire code_byte  = status_code == DCHAB_CODE_DCHAN_BYTE;
  wire act_ok     = is_act_ok(LINE_ACT_EVT.code);
  wire act_err    = LINE_ACT_EVT.code == DCHAB_CODE_ACT_ERROR;
  // an activation outcome that meets a live byte code must wait
  wire act_defer  = code_byte || byte_irq;
  wire act_take   = LINE_ACT_EVT.valid && !act_defer;
  // a new byte on the read edge keeps the outcome pending for the next read
  wire pend_rel   = act_pending && rd_data && !byte_irq;
  wire src_act    = status_code != DCHAB_CODE_NONE;

  // a deferred outcome raises its sticky bit only when it is finally signalled
  wire       act_fire  = act_take || pend_rel;
  wire [3:0] fire_code = act_take ? LINE_ACT_EVT.code : act_pending_code;
  wire       fire_err  = fire_code == DCHAB_CODE_ACT_ERROR;
  wire       fire_ok   = is_act_ok(fire_code);

  wire [2:0] evt_set = {act_fire && fire_err, act_fire && fire_ok, byte_irq};

  wire [7:0] rdata_mux =
      (HOST_REQ.addr == DCHAB_ADDR_RESET_CTRL)  ? {4'h0, reset_ctrl}  :
      (HOST_REQ.addr == DCHAB_ADDR_STATUS_CODE) ? {4'h0, status_code} :
      (HOST_REQ.addr == DCHAB_ADDR_ACT_CTRL)    ? {4'h0, act_ctrl}    :
      (HOST_REQ.addr == DCHAB_ADDR_IRQ_SOURCE)  ? {4'h0, src_act, 3'h0} :
      (HOST_REQ.addr == DCHAB_ADDR_IRQ_ENABLE)  ? {4'h0, irq_enable}  :
      (HOST_REQ.addr == DCHAB_ADDR_BYTE_CTRL)   ? {6'h00, byte_ctrl}  :
      (HOST_REQ.addr == DCHAB_ADDR_DCHAN_DATA)  ? (path_live ? rx_byte : 8'h00) :
      (HOST_REQ.addr == DCHAB_ADDR_EVT_STATUS)  ? {5'h00, evt_status} :
      (HOST_REQ.addr == DCHAB_ADDR_EVT_MASK)    ? {5'h00, evt_mask}   : 8'h00;

  // ***********************************************************
  // host port registers
  // ***********************************************************
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      reset_ctrl <= DCHAB_RST_NIBBLE;
      act_ctrl   <= DCHAB_RST_NIBBLE;
      irq_enable <= DCHAB_RST_NIBBLE;
      byte_ctrl  <= 2'h0;
      tx_byte    <= DCHAB_RST_BYTE;
      evt_mask   <= DCHAB_RST_EVT;
      HOST_RDATA <= DCHAB_RST_BYTE;
    end else begin
      if (wr_reset) reset_ctrl <= HOST_REQ.wdata[3:0];
      if (wr_act) act_ctrl <= HOST_REQ.wdata[3:0];
      if (wr_irqen) irq_enable <= HOST_REQ.wdata[3:0];
      if (wr_bctrl) byte_ctrl <= HOST_REQ.wdata[1:0];
      if (wr_data && path_live) tx_byte <= HOST_REQ.wdata;
      if (wr_mask) evt_mask <= HOST_REQ.wdata[2:0];
      HOST_RDATA <= HOST_REQ.rd ? rdata_mux : 8'h00;
    end
  end

  // ***********************************************************
  // status code and deferred activation
  // ***********************************************************
  always_ff @(posedge CLK) begin
    if (SYS_RST || reset_ctrl[DCHAB_BIT_SOFT_RESET]) begin
      status_code      <= DCHAB_CODE_NONE;
      activated        <= 1'b0;
      act_pending      <= 1'b0;
      act_pending_code <= DCHAB_CODE_NONE;
      period_cnt       <= 15'h0000;
      rx_byte          <= DCHAB_RST_BYTE;
    end else begin
      period_cnt <= (!path_live || period_end) ? 15'h0000 : period_cnt + 15'h0001;
      if (byte_tick) rx_byte <= LINE_RX_BYTE;
      if (LINE_ACT_EVT.valid && act_ok) activated <= 1'b1;
      if (LINE_ACT_EVT.valid && act_defer) begin
        act_pending      <= 1'b1;
        act_pending_code <= LINE_ACT_EVT.code;
      end else if (pend_rel) begin
        act_pending <= 1'b0;
      end
      // new byte wins over a clear on the same edge
      if (byte_irq) status_code <= DCHAB_CODE_DCHAN_BYTE;
      else if (act_take) status_code <= LINE_ACT_EVT.code;
      else if (pend_rel) status_code <= act_pending_code;
      else if (rd_data && code_byte) status_code <= DCHAB_CODE_NONE;
      else if (HOST_REQ.rd && HOST_REQ.addr == DCHAB_ADDR_STATUS_CODE && !code_byte)
        status_code <= DCHAB_CODE_NONE;
    end
  end

  // ***********************************************************
  // sticky events, write one to clear, set wins
  // ***********************************************************
  always_ff @(posedge CLK) begin
    if (SYS_RST) evt_status <= DCHAB_RST_EVT;
    else evt_status <= (evt_status & ~(wr_evt ? HOST_REQ.wdata[2:0] : 3'h0)) | evt_set;
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  // interrupt level follows the code nibble only when the shared line is enabled
  assign IRQ             = (irq_en && src_act) || |(evt_status & evt_mask);
  assign LINE_TX_BYTE    = tx_byte;
  assign LINE_TX_STROBE  = byte_tick;
  assign LINE_ACT_REQ    = act_ctrl[DCHAB_BIT_ACT_REQUEST];
  assign LINE_CUST_EN    = act_ctrl[DCHAB_BIT_CUST_ENABLE];
  assign LINE_SOFT_RESET = reset_ctrl[DCHAB_BIT_SOFT_RESET];

endmodule : dchab_top

// File: dv/dchab_checker.sv
/*
  port checker for dchab_top, bound to every instance.
  assumes one clock CLK and the synchronous active-high SYS_RST.
*/
module dchab_checker
  import dchab_pkg::*;
(
  input wire logic                  CLK,
  input wire logic                  SYS_RST,
  input wire dchab_pkg::dchab_req_t HOST_REQ,
  input wire logic [7:0]            HOST_RDATA,
  input wire logic                  IRQ,
  input wire logic                  LINE_TRANSPARENT,
  input wire logic                  LINE_TX_STROBE,
  input wire logic                  LINE_ACT_REQ,
  input wire logic                  LINE_CUST_EN
);
  // ***********************************************************
  // assertions
  // ***********************************************************
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  wire         rd_stat = HOST_REQ.rd && HOST_REQ.addr == DCHAB_ADDR_STATUS_CODE && !LINE_TX_STROBE;
  wire         rd_data = HOST_REQ.rd && HOST_REQ.addr == DCHAB_ADDR_DCHAN_DATA && !LINE_TX_STROBE;
  wire         wr_act  = HOST_REQ.wr && HOST_REQ.addr == DCHAB_ADDR_ACT_CTRL;
  logic [15:0] gap;
  // saturates at system reset so the first strobe after SYS_RST never trips the period check
  always_ff @(posedge CLK) begin
    if (SYS_RST) gap <= 16'hFFFF;
    else if (LINE_TX_STROBE) gap <= 16'h0001;
    else if (gap != 16'hFFFF) gap <= gap + 16'h0001;
  end
  property p_rdata_idle; !$past(HOST_REQ.rd) |-> HOST_RDATA == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");
  property p_refused; HOST_REQ.rd && HOST_REQ.addr == DCHAB_ADDR_DCHAN_DATA && !LINE_TRANSPARENT |=> HOST_RDATA == 8'h00; endproperty
  a_refused: assert property (p_refused) else $error("data read while path closed");
  property p_strobe_pulse; LINE_TX_STROBE |=> !LINE_TX_STROBE; endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe longer than one cycle");
  property p_strobe_period; LINE_TX_STROBE |-> gap >= DCHAN_PERIOD_CYC; endproperty
  a_strobe_period: assert property (p_strobe_period) else $error("byte period too short");
  property p_act_req; wr_act |=> LINE_ACT_REQ == $past(HOST_REQ.wdata[DCHAB_BIT_ACT_REQUEST]); endproperty
  a_act_req: assert property (p_act_req) else $error("activation request not from write");
  property p_cust_en; wr_act |=> LINE_CUST_EN == $past(HOST_REQ.wdata[DCHAB_BIT_CUST_ENABLE]); endproperty
  a_cust_en: assert property (p_cust_en) else $error("customer enable not from write");
  property p_irq_code; rd_stat ##1 HOST_RDATA[3:0] == DCHAB_CODE_DCHAN_BYTE |-> IRQ; endproperty
  a_irq_code: assert property (p_irq_code) else $error("byte code without interrupt");
  property p_code_clear; rd_data ##1 !LINE_TX_STROBE ##1 rd_stat |=> HOST_RDATA[3:0] != DCHAB_CODE_DCHAN_BYTE; endproperty
  a_code_clear: assert property (p_code_clear) else $error("byte code kept after data read");
  c_code_clear: cover property (p_code_clear);
  c_strobe: cover property (LINE_TX_STROBE);
  c_act_req: cover property (wr_act ##1 LINE_ACT_REQ);
endmodule : dchab_checker

bind dchab_top dchab_checker u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .HOST_REQ(HOST_REQ), .HOST_RDATA(HOST_RDATA),
  .IRQ(IRQ), .LINE_TRANSPARENT(LINE_TRANSPARENT), .LINE_TX_STROBE(LINE_TX_STROBE),
  .LINE_ACT_REQ(LINE_ACT_REQ), .LINE_CUST_EN(LINE_CUST_EN));

// File: dv/dchab_line_model.sv
/*
  line-side model: activation outcome on command, transparent mode once
  customer data is on, a new received byte each period. assumes CLK domain.
*/
module dchab_line_model
  import dchab_pkg::*;
(
  input  wire logic                  CLK,
  input  wire logic                  SYS_RST,
  input  wire logic                  go,
  input  wire logic [3:0]            code,
  input  wire logic                  LINE_CUST_EN,
  input  wire logic                  LINE_TX_STROBE,
  output dchab_pkg::dchab_act_evt_t  LINE_ACT_EVT = '0,
  output logic                       LINE_TRANSPARENT = 1'b0,
  output logic [7:0]                 LINE_RX_BYTE = 8'h00
);
  // idle code is the inverse so a stale outcome is never mistaken for a fresh one
  always @(posedge CLK) begin
    LINE_ACT_EVT <= '{valid: go, code: go ? code : ~code};
    LINE_TRANSPARENT <= LINE_CUST_EN && !SYS_RST;
    if (SYS_RST) LINE_RX_BYTE <= 8'h3C;
    else if (LINE_TX_STROBE) LINE_RX_BYTE <= LINE_RX_BYTE + 8'h11;
  end
endmodule : dchab_line_model

// File: dv/testbench.sv
/*
  self-checking bench for dchab_top with host register tasks and a line model.
  assumes the fixed 12500-cycle byte period of the design.
*/
module testbench
  import dchab_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clk = 1'b0;
  logic                  sys_rst = 1'b1;
  dchab_req_t            req = '0;
  logic                  go = 1'b0;
  logic [3:0]            code = 4'h0;
  logic [7:0]            exp_rx;
  dchab_act_evt_t        act_evt;
  logic                  transparent, tx_strobe, act_req, cust_en, soft_rst, irq;
  logic [7:0]            rx_byte, tx_byte, host_rdata;
  int                    err_total = 0;
  int                    n_checks = 0;
  dchab_top uut (.CLK(clk), .SYS_RST(sys_rst), .HOST_REQ(req), .HOST_RDATA(host_rdata), .IRQ(irq),
    .LINE_ACT_EVT(act_evt), .LINE_TRANSPARENT(transparent), .LINE_RX_BYTE(rx_byte), .LINE_TX_BYTE(tx_byte),
    .LINE_TX_STROBE(tx_strobe), .LINE_ACT_REQ(act_req), .LINE_CUST_EN(cust_en), .LINE_SOFT_RESET(soft_rst));
  dchab_line_model line (.CLK(clk), .SYS_RST(sys_rst), .go(go), .code(code), .LINE_CUST_EN(cust_en),
    .LINE_TX_STROBE(tx_strobe), .LINE_ACT_EVT(act_evt), .LINE_TRANSPARENT(transparent), .LINE_RX_BYTE(rx_byte));
  // ***********************************************************
  // tasks
  // ***********************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    n_checks++;
    if (seen !== want) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk(host_rdata, want);
  endtask : rd
  task automatic pulse(input logic [3:0] c);
    @(posedge clk);
    go <= 1'b1;
    code <= c;
    @(posedge clk);
    go <= 1'b0;
  endtask : pulse
  task automatic wait_for(input bit strobe);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((strobe ? tx_strobe : irq) !== 1'b1 && n < 13000);
    chk({7'h00, n < 13000}, 8'h01);
    exp_rx = rx_byte;
  endtask : wait_for
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // ***********************************************************
  // clock, watchdog and sequence
  // ***********************************************************
  initial begin
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(DCHAB_ADDR_STATUS_CODE, 8'h00);
    rd(DCHAB_ADDR_DCHAN_DATA, 8'h00);
    rd(8'h3C, 8'h00);
    wr(DCHAB_ADDR_RESET_CTRL, 8'h08);
    chk({7'h00, soft_rst}, 8'h01);
    wr(DCHAB_ADDR_RESET_CTRL, 8'h00);
    wr(DCHAB_ADDR_BYTE_CTRL, 8'h02);
    wr(DCHAB_ADDR_IRQ_ENABLE, 8'h08);
    wr(DCHAB_ADDR_ACT_CTRL, 8'h08);
    chk({7'h00, act_req}, 8'h01);
    pulse(DCHAB_CODE_ACT_OK_A);
    wait_for(1'b0);
    rd(DCHAB_ADDR_IRQ_SOURCE, 8'h08);
    rd(DCHAB_ADDR_STATUS_CODE, 8'h0A);
    chk({7'h00, irq}, 8'h00);
    wr(DCHAB_ADDR_ACT_CTRL, 8'h09);
    chk({7'h00, cust_en}, 8'h01);
    wr(DCHAB_ADDR_DCHAN_DATA, 8'h5A);
    wait_for(1'b1);
    chk(tx_byte, 8'h5A);
    rd(DCHAB_ADDR_STATUS_CODE, 8'h0F);
    chk({7'h00, irq}, 8'h01);
    rd(DCHAB_ADDR_DCHAN_DATA, exp_rx);
    rd(DCHAB_ADDR_STATUS_CODE, 8'h00);
    wait_for(1'b1);
    pulse(DCHAB_CODE_ACT_ERROR);
    rd(DCHAB_ADDR_STATUS_CODE, 8'h0F);
    rd(DCHAB_ADDR_DCHAN_DATA, exp_rx);
    chk({7'h00, irq}, 8'h01);
    rd(DCHAB_ADDR_STATUS_CODE, 8'h04);
    wr(DCHAB_ADDR_IRQ_ENABLE, 8'h00);
    wr(DCHAB_ADDR_EVT_MASK, 8'h07);
    chk({7'h00, irq}, 8'h01);
    rd(DCHAB_ADDR_EVT_STATUS, 8'h07);
    wr(DCHAB_ADDR_EVT_STATUS, 8'h07);
    chk({7'h00, irq}, 8'h00);
    end_sim();
  end
endmodule : testbench
